/* src/sid_dispatch.sv */
`timescale 1ns/1ps
// Contract
// - Task gate entry performs an implicit task switch into the handler task.
// - Task switch saves full interrupted state and restores it on return.
// - Real mode answers interrupts with an implicit far call to the handler.
// - Real mode indexes the handler pointer table by vector number.
// - Real mode pushes flags, code selector, pointer and optional error code.
// - Handler return instruction pops saved state and resumes interrupted code.
// - Opcode CD with immediate vector dispatches to that vector.
// - Opcode CE traps to the overflow vector only when overflow flag set.
// - Arithmetic overflow never raises the overflow exception by itself.
// - Overflow exception uses vector 4, shared with software interrupt 4.
// - Opcode CC always raises the breakpoint exception.
// - Opcode F1 always raises the debug exception.
// - Range check compares operand to memory limits, traps when outside.
// - Range-exceeded uses vector 5, only from range check or interrupt 5.
// - No implicit bounds checks; range exceeded never raised spontaneously.
// - Legacy floating-point errors report through the legacy error vector.
// - Packed-vector floating-point errors report through the vector exception.
// - In 64-bit mode every table handler runs as 64-bit code.
// - In 64-bit mode every stack push is an 8-byte zero-extended store.
// - In 64-bit mode stack selector and pointer are always pushed.
// - In 64-bit mode a privilege change loads a null stack selector.
// - Same-stack push order: flags, code selector, pointer, then error code.
// - Interrupt-type gate entry clears the interrupt-enable flag.
module sid_dispatch
    import sid_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Instruction stream
    input wire logic instr_valid_i,
    input wire logic [7:0] opcode_i,
    input wire logic [7:0] imm_i,
    input wire logic [63:0] ip_i,
    input wire logic [63:0] next_ip_i,
    // Other exception sources
    input wire logic exc_valid_i,
    input wire logic [7:0] exc_vec_i,
    input wire logic exc_err_valid_i,
    input wire logic [31:0] exc_err_i,
    input wire logic fp_legacy_err_i,
    input wire logic fp_vector_err_i,
    // Range check operand
    input wire logic [31:0] range_op_i,
    input wire logic [63:0] range_addr_i,
    // Architectural state
    input wire logic [31:0] flags_i,
    input wire logic [15:0] cs_i,
    input wire logic [15:0] ss_i,
    input wire logic [63:0] sp_i,
    input wire logic [1:0] cpl_i,
    input wire logic [15:0] priv_ss_i,
    input wire logic [63:0] priv_sp_i,
    // Memory port
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [63:0] mem_addr_o,
    output logic [63:0] mem_wdata_o,
    output logic [1:0] mem_size_o,
    input wire logic mem_ack_i,
    input wire logic [63:0] mem_rdata_i,
    // Results
    output logic busy_o,
    output logic done_o,
    output logic load_o,
    output logic task_switch_o,
    output logic code64_o,
    output logic [7:0] vector_o,
    output logic [63:0] new_ip_o,
    output logic [15:0] new_cs_o,
    output logic [31:0] new_flags_o,
    output logic [15:0] new_ss_o,
    output logic [63:0] new_sp_o
);

    sid_state_t state_reg;
    logic [1:0] mode_reg;
    logic [31:0] tbase_reg;
    logic [31:0] sbase_reg;
    logic in_task_reg;
    logic op_task_reg;
    logic ret_reg;
    logic gate_int_reg;
    logic has_err_reg;
    logic [2:0] idx_reg;
    logic [7:0] vec_reg;
    logic [31:0] err_reg;
    logic [31:0] lo_reg;
    logic [63:0] addr_reg;
    logic [63:0] sv_ip;
    logic [15:0] sv_cs;
    logic [15:0] sv_ss;
    logic [63:0] sv_sp;
    logic [31:0] sv_flags;
    logic [63:0] h_ip;
    logic [15:0] h_cs;
    logic [15:0] h_ss;
    logic [63:0] h_sp;

    // Register bus decode
    wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr = wb_hit & wb_we_i;
    wire [31:0] wmask;
    genvar b;
    generate
        for (b = 0; b < 4; b++)
        begin : g_lane
            assign wmask[8*b +: 8] = {8{wb_sel_i[b]}};
        end
    endgenerate
    wire [31:0] stat_word = {20'h0_0000, in_task_reg, state_reg, vec_reg};
    wire [31:0] rd_data =
        (wb_adr_i == REG_CTRL) ? {30'h0000_0000, mode_reg} :
        (wb_adr_i == REG_TBASE) ? tbase_reg :
        (wb_adr_i == REG_SBASE) ? sbase_reg :
        (wb_adr_i == REG_STAT) ? stat_word : 32'h0000_0000;

    // Mode and sizing
    wire is_real = mode_reg == MODE_REAL;
    wire is_long = mode_reg == MODE_LONG;
    wire [1:0] mode_sz = is_real ? SZ_2 : (is_long ? SZ_8 : SZ_4);
    wire [1:0] cur_sz = op_task_reg ? SZ_8 : mode_sz;
    wire [63:0] sz_bytes = (cur_sz == SZ_2) ? SZB_2 :
        (cur_sz == SZ_4) ? SZB_4 : SZB_8;
    wire [63:0] sz_mask = (cur_sz == SZ_2) ? 64'h0000_0000_0000_ffff :
        (cur_sz == SZ_4) ? 64'h0000_0000_ffff_ffff :
        64'hffff_ffff_ffff_ffff;
    wire [63:0] pop_val = mem_rdata_i & sz_mask;

    // Start of work, fixed priority: legacy FP error, vector FP error, exception, then instruction 
    wire take_fpl = fp_legacy_err_i;
    wire take_fpv = ~take_fpl & fp_vector_err_i;
    wire take_exc = ~take_fpl & ~take_fpv & exc_valid_i;
    wire take_ins = ~take_fpl & ~take_fpv & ~exc_valid_i & instr_valid_i;
    wire op_ovf_trap = (opcode_i == OP_OVF) & flags_i[FLAG_OF];
    wire ins_trap = take_ins & ((opcode_i == OP_SWINT) |
        (opcode_i == OP_BRK) | (opcode_i == OP_DBG) | op_ovf_trap);
    wire ins_quiet = take_ins & (opcode_i == OP_OVF) & ~flags_i[FLAG_OF];
    wire ins_range = take_ins & (opcode_i == OP_RANGE);
    wire ins_ret = take_ins & (opcode_i == OP_RET);
    wire [7:0] ins_vec = (opcode_i == OP_SWINT) ? imm_i :
        (opcode_i == OP_BRK) ? VEC_BP :
        (opcode_i == OP_DBG) ? VEC_DB : VEC_OF;
    wire [7:0] start_vec = take_fpl ? VEC_MF :
        take_fpv ? VEC_XM :
        take_exc ? exc_vec_i : ins_vec;
    wire start_trap = take_fpl | take_fpv | take_exc | ins_trap;
    wire [63:0] start_ip = take_ins ? next_ip_i : ip_i;

    // Handler table lookup
    wire [63:0] vec_off = is_real ?
        ({56'h0000_0000_0000_00, vec_reg} << TBL_SHIFT_REAL) :
        ({56'h0000_0000_0000_00, vec_reg} << TBL_SHIFT_PROT);
    wire [63:0] desc_addr = {32'h0000_0000, tbase_reg} + vec_off;
    wire [1:0] d_type = mem_rdata_i[DSC_TYPE_LSB +: 2];
    wire [1:0] d_dpl = mem_rdata_i[DSC_DPL_LSB +: 2];
    wire d_change = d_dpl < cpl_i;
    wire d_switch = is_long | d_change;

    // Frame contents, zero-extended to the store width
    wire [15:0] h_cs_save = sv_cs;
    wire [63:0] push_val =
        (idx_reg == IT_SS) ? {48'h0000_0000_0000, sv_ss} :
        (idx_reg == IT_SP) ? sv_sp :
        (idx_reg == IT_FLAGS) ? {32'h0000_0000, sv_flags} :
        (idx_reg == IT_CS) ? {48'h0000_0000_0000, h_cs_save} :
        (idx_reg == IT_IP) ? sv_ip : {32'h0000_0000, err_reg};
    wire push_last = (idx_reg == IT_ERR) | ((idx_reg == IT_IP) & ~has_err_reg);
    wire pop_stack = op_task_reg |
        (~is_real & (is_long | (h_cs[1:0] != cpl_i)));
    wire pop_last = (idx_reg == IT_SS) | ((idx_reg == IT_FLAGS) & ~pop_stack);
    wire [31:0] range_cmp = err_reg;
    wire range_out = ($signed(range_cmp) < $signed(lo_reg)) |
        ($signed(range_cmp) > $signed(mem_rdata_i[31:0]));

    // Register bus
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            mode_reg <= CTRL_RST;
            tbase_reg <= BASE_RST;
            sbase_reg <= BASE_RST;
        end
        else
        begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= wb_hit ? rd_data : 32'h0000_0000;
            if (wb_wr && wb_adr_i == REG_CTRL)
                mode_reg <= (mode_reg & ~wmask[1:0]) | (wb_dat_i[1:0] & wmask[1:0]);
            if (wb_wr && wb_adr_i == REG_TBASE)
                tbase_reg <= (tbase_reg & ~wmask) | (wb_dat_i & wmask);
            if (wb_wr && wb_adr_i == REG_SBASE)
                sbase_reg <= (sbase_reg & ~wmask) | (wb_dat_i & wmask);
        end
    end

    // Dispatch sequencer; every memory step issues, then waits for ack
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            state_reg <= ST_IDLE;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            load_o <= 1'b0;
            task_switch_o <= 1'b0;
            code64_o <= 1'b0;
            vector_o <= 8'h00;
            new_ip_o <= 64'h0000_0000_0000_0000;
            new_cs_o <= 16'h0000;
            new_flags_o <= 32'h0000_0000;
            new_ss_o <= 16'h0000;
            new_sp_o <= 64'h0000_0000_0000_0000;
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_addr_o <= 64'h0000_0000_0000_0000;
            mem_wdata_o <= 64'h0000_0000_0000_0000;
            mem_size_o <= SZ_2;
            in_task_reg <= 1'b0;
            op_task_reg <= 1'b0;
            ret_reg <= 1'b0;
            gate_int_reg <= 1'b0;
            has_err_reg <= 1'b0;
            idx_reg <= IT_SS;
            vec_reg <= 8'h00;
            err_reg <= 32'h0000_0000;
            lo_reg <= 32'h0000_0000;
            addr_reg <= 64'h0000_0000_0000_0000;
            sv_ip <= 64'h0000_0000_0000_0000;
            sv_cs <= 16'h0000;
            sv_ss <= 16'h0000;
            sv_sp <= 64'h0000_0000_0000_0000;
            sv_flags <= 32'h0000_0000;
            h_ip <= 64'h0000_0000_0000_0000;
            h_cs <= 16'h0000;
            h_ss <= 16'h0000;
            h_sp <= 64'h0000_0000_0000_0000;
        end
        else
        begin
            done_o <= 1'b0;
            load_o <= 1'b0;
            task_switch_o <= 1'b0;
            unique case (state_reg)
                ST_IDLE:
                begin
                    sv_ip <= start_ip;
                    sv_cs <= cs_i;
                    sv_ss <= ss_i;
                    sv_sp <= sp_i;
                    sv_flags <= flags_i;
                    has_err_reg <= take_exc & exc_err_valid_i;
                    err_reg <= ins_range ? range_op_i : exc_err_i;
                    op_task_reg <= 1'b0;
                    ret_reg <= 1'b0;
                    done_o <= ins_quiet;
                    if (start_trap)
                    begin
                        vec_reg <= start_vec;
                        busy_o <= 1'b1;
                        state_reg <= ST_DESC;
                    end
                    else if (ins_range)
                    begin
                        addr_reg <= range_addr_i;
                        busy_o <= 1'b1;
                        state_reg <= ST_RLO;
                    end
                    else if (ins_ret)
                    begin
                        // Task return pops from the save area instead
                        op_task_reg <= in_task_reg;
                        ret_reg <= 1'b1;
                        gate_int_reg <= 1'b0;
                        h_ss <= ss_i;
                        addr_reg <= in_task_reg ?
                            {32'h0000_0000, sbase_reg} - SAVE_BYTES : sp_i;
                        idx_reg <= IT_IP;
                        busy_o <= 1'b1;
                        state_reg <= ST_POP;
                    end
                end
                ST_RLO, ST_RHI:
                begin
                    if (!mem_req_o)
                    begin
                        mem_req_o <= 1'b1;
                        mem_we_o <= 1'b0;
                        mem_size_o <= SZ_4;
                        mem_addr_o <= (state_reg == ST_RHI) ?
                            addr_reg + RANGE_HI_OFS : addr_reg;
                    end
                    else if (mem_ack_i)
                    begin
                        mem_req_o <= 1'b0;
                        lo_reg <= mem_rdata_i[31:0];
                        if (state_reg == ST_RLO)
                            state_reg <= ST_RHI;
                        else if (range_out)
                        begin
                            vec_reg <= VEC_BR;
                            state_reg <= ST_DESC;
                        end
                        else
                        begin
                            done_o <= 1'b1;
                            busy_o <= 1'b0;
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_DESC:
                begin
                    if (!mem_req_o)
                    begin
                        mem_req_o <= 1'b1;
                        mem_we_o <= 1'b0;
                        mem_size_o <= is_real ? SZ_4 : SZ_8;
                        mem_addr_o <= desc_addr;
                    end
                    else if (mem_ack_i)
                    begin
                        mem_req_o <= 1'b0;
                        vector_o <= vec_reg;
                        state_reg <= ST_PUSH;
                        if (is_real)
                        begin
                            // Far call through the pointer table
                            h_ip <= {48'h0000_0000_0000, mem_rdata_i[15:0]};
                            h_cs <= mem_rdata_i[RDSC_SEG_LSB +: 16];
                            h_ss <= ss_i;
                            gate_int_reg <= 1'b1;
                            addr_reg <= sp_i;
                            idx_reg <= IT_FLAGS;
                        end
                        else
                        begin
                            h_ip <= {32'h0000_0000, mem_rdata_i[31:0]};
                            h_cs <= mem_rdata_i[DSC_SEL_LSB +: 16];
                            gate_int_reg <= d_type == GATE_INT;
                            if (d_type == GATE_TASK)
                            begin
                                // Whole state goes to the save area
                                op_task_reg <= 1'b1;
                                h_ss <= ss_i;
                                addr_reg <= {32'h0000_0000, sbase_reg};
                                idx_reg <= IT_SS;
                            end
                            else
                            begin
                                h_ss <= !d_change ? ss_i :
                                    is_long ? NULL_SEL : priv_ss_i;
                                addr_reg <= d_change ? priv_sp_i : sp_i;
                                idx_reg <= d_switch ? IT_SS : IT_FLAGS;
                            end
                        end
                    end
                end
                ST_PUSH:
                begin
                    if (!mem_req_o)
                    begin
                        mem_req_o <= 1'b1;
                        mem_we_o <= 1'b1;
                        mem_size_o <= cur_sz;
                        mem_addr_o <= addr_reg - sz_bytes;
                        mem_wdata_o <= push_val & sz_mask;
                        addr_reg <= addr_reg - sz_bytes;
                    end
                    else if (mem_ack_i)
                    begin
                        mem_req_o <= 1'b0;
                        mem_we_o <= 1'b0;
                        idx_reg <= idx_reg + 3'h1;
                        if (push_last)
                        begin
                            h_sp <= op_task_reg ? sv_sp : addr_reg;
                            state_reg <= ST_LOAD;
                        end
                    end
                end
                ST_POP:
                begin
                    if (!mem_req_o)
                    begin
                        mem_req_o <= 1'b1;
                        mem_we_o <= 1'b0;
                        mem_size_o <= cur_sz;
                        mem_addr_o <= addr_reg;
                        addr_reg <= addr_reg + sz_bytes;
                    end
                    else if (mem_ack_i)
                    begin
                        mem_req_o <= 1'b0;
                        idx_reg <= idx_reg - 3'h1;
                        unique case (idx_reg)
                            IT_IP: h_ip <= pop_val;
                            IT_CS: h_cs <= pop_val[15:0];
                            IT_FLAGS: sv_flags <= pop_val[31:0];
                            IT_SP: h_sp <= pop_val;
                            default: h_ss <= pop_val[15:0];
                        endcase
                        if (pop_last)
                            state_reg <= ST_LOAD;
                        if (idx_reg == IT_FLAGS && !pop_stack)
                            h_sp <= addr_reg;
                    end
                end
                ST_LOAD:
                begin
                    load_o <= 1'b1;
                    done_o <= 1'b1;
                    busy_o <= 1'b0;
                    task_switch_o <= op_task_reg;
                    if (op_task_reg)
                        in_task_reg <= ~ret_reg;
                    code64_o <= is_long;
                    new_ip_o <= h_ip;
                    new_cs_o <= h_cs;
                    new_ss_o <= h_ss;
                    new_sp_o <= h_sp;
                    new_flags_o <= gate_int_reg ?
                        sv_flags & ~(32'h0000_0001 << FLAG_IF) : sv_flags;
                    state_reg <= ST_IDLE;
                end
                default:
                begin
                    busy_o <= 1'b0;
                    mem_req_o <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // sid_dispatch

/* src/sid_pkg.sv */
package sid_pkg;
    // Opcodes
    localparam logic [7:0] OP_SWINT = 8'hcd;
    localparam logic [7:0] OP_OVF = 8'hce;
    localparam logic [7:0] OP_BRK = 8'hcc;
    localparam logic [7:0] OP_DBG = 8'hf1;
    localparam logic [7:0] OP_RET = 8'hcf;
    localparam logic [7:0] OP_RANGE = 8'h62;
    // Vectors
    localparam logic [7:0] VEC_DB = 8'h01;
    localparam logic [7:0] VEC_BP = 8'h03;
    localparam logic [7:0] VEC_OF = 8'h04;
    localparam logic [7:0] VEC_BR = 8'h05;
    localparam logic [7:0] VEC_MF = 8'h10;
    localparam logic [7:0] VEC_XM = 8'h13;
    // Operating modes
    localparam logic [1:0] MODE_REAL = 2'h0;
    localparam logic [1:0] MODE_PROT = 2'h1;
    localparam logic [1:0] MODE_LONG = 2'h2;
    // Handler table entry and index shifts, real (RDSC_, REAL) and protected/64-bit modes
    localparam logic [1:0] GATE_INT = 2'h0;
    localparam logic [1:0] GATE_TRAP = 2'h1;
    localparam logic [1:0] GATE_TASK = 2'h2;
    localparam int DSC_SEL_LSB = 32;
    localparam int DSC_TYPE_LSB = 48;
    localparam int DSC_DPL_LSB = 50;
    localparam int RDSC_SEG_LSB = 16;
    localparam int TBL_SHIFT_REAL = 2;
    localparam int TBL_SHIFT_PROT = 3;
    // Flags register bits
    localparam int FLAG_IF = 9;
    localparam int FLAG_OF = 11;
    // Memory access size codes and byte counts
    localparam logic [1:0] SZ_2 = 2'h0;
    localparam logic [1:0] SZ_4 = 2'h1;
    localparam logic [1:0] SZ_8 = 2'h2;
    localparam logic [63:0] SZB_2 = 64'h2;
    localparam logic [63:0] SZB_4 = 64'h4;
    localparam logic [63:0] SZB_8 = 64'h8;
    localparam logic [63:0] RANGE_HI_OFS = 64'h4;
    localparam logic [63:0] SAVE_BYTES = 64'h28;
    localparam logic [15:0] NULL_SEL = 16'h0000;
    // Stack frame items, in push order
    localparam logic [2:0] IT_SS = 3'h0;
    localparam logic [2:0] IT_SP = 3'h1;
    localparam logic [2:0] IT_FLAGS = 3'h2;
    localparam logic [2:0] IT_CS = 3'h3;
    localparam logic [2:0] IT_IP = 3'h4;
    localparam logic [2:0] IT_ERR = 3'h5;
    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TBASE = 8'h04;
    localparam logic [7:0] REG_SBASE = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0c;
    localparam logic [1:0] CTRL_RST = MODE_REAL;
    localparam logic [31:0] BASE_RST = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DESC = 3'b001,
        ST_PUSH = 3'b011,
        ST_LOAD = 3'b010,
        ST_RLO = 3'b110,
        ST_RHI = 3'b111,
        ST_POP = 3'b100
    } sid_state_t;
endpackage

/* tb/sid_dispatch_assertions.sv */
`timescale 1ns/1ps
module sid_dispatch_assertions
    import sid_pkg::*;
(
    // Inputs
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic instr_valid_i,
    input wire logic [7:0] opcode_i,
    input wire logic [31:0] flags_i,
    input wire logic exc_valid_i,
    input wire logic fp_legacy_err_i,
    input wire logic fp_vector_err_i,
    input wire logic mem_ack_i,
    // Outputs
    input wire logic wb_ack_o,
    input wire logic mem_req_o,
    input wire logic [63:0] mem_addr_o,
    input wire logic [1:0] mem_size_o,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic load_o,
    input wire logic task_switch_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    wire fp_any = fp_legacy_err_i | fp_vector_err_i;
    wire src_any = instr_valid_i | exc_valid_i | fp_any;
    wire ovf_quiet = instr_valid_i && !busy_o && opcode_i == OP_OVF
        && !flags_i[FLAG_OF] && !exc_valid_i && !fp_any;
    a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("bus ack missing");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack too long");
    a_mem_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o
        && $stable(mem_addr_o) && $stable(mem_size_o))
        else $error("memory request changed");
    a_ovf_quiet: assert property (
        ovf_quiet |-> ##[1:2] (done_o && !load_o))
        else $error("overflow trap with flag clear");
    a_no_spont: assert property (
        $rose(busy_o) |-> $past(src_any)) else $error("busy without cause");
    a_task_load: assert property (
        task_switch_o |-> load_o) else $error("task switch without load");
    a_load_done: assert property (
        load_o |-> done_o) else $error("load without done");
    a_work_bounded: assert property ($rose(busy_o) |-> ##[1:300] done_o)
        else $error("dispatch never finished");
    cover property (load_o && task_switch_o);
    cover property (done_o && !load_o);
    cover property (mem_req_o && mem_size_o == SZ_8);
endmodule // sid_dispatch_assertions
bind sid_dispatch sid_dispatch_assertions u_chk (.*);

/* tb/test_sid_dispatch.sv */
`timescale 1ns/1ps
module test_sid_dispatch
    import sid_pkg::*;
;
logic ref_clk_i = 0, reset_n_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
logic instr_valid_i = 0, exc_valid_i = 0, exc_err_valid_i = 0;
logic fp_legacy_err_i = 0, fp_vector_err_i = 0, mem_ack_i = 0;
logic [7:0] wb_adr_i = '0, opcode_i = '0, imm_i = '0, exc_vec_i = '0;
logic [3:0] wb_sel_i = '0;
logic [1:0] cpl_i = '0, mem_size_o;
logic [15:0] cs_i = '0, ss_i = '0, priv_ss_i = '0, new_cs_o, new_ss_o;
logic [31:0] wb_dat_i = '0, exc_err_i = '0, flags_i = '0, range_op_i = '0;
logic [63:0] ip_i = '0, next_ip_i = '0, range_addr_i = '0, sp_i = '0;
logic [63:0] priv_sp_i = '0, mem_rdata_i = '0;
logic [31:0] wb_dat_o, new_flags_o, q;
logic wb_ack_o, mem_req_o, mem_we_o, busy_o, done_o, load_o;
logic task_switch_o, code64_o, ld, ts;
logic [63:0] mem_addr_o, mem_wdata_o, new_ip_o, new_sp_o;
logic [7:0] vector_o;
logic [63:0] mem [logic [63:0]];
logic [63:0] wq [$];
logic [1:0] szq [$];
int err_total = 0, total_checks = 0, cyc = 0;
always #4 ref_clk_i = ~ref_clk_i;
sid_dispatch dut (.*);
// Memory answers one cycle after request; idle data toggles
always @(posedge ref_clk_i)
begin
    cyc++;
    if (cyc == 20000)
    begin
        err_total++;
        tally_and_finish();
    end
    mem_ack_i <= 1'b0;
    mem_rdata_i <= ~mem_rdata_i;
    if (mem_req_o && !mem_ack_i)
    begin
        mem_ack_i <= 1'b1;
        if (mem_we_o)
        begin
            mem[mem_addr_o] = mem_wdata_o;
            wq.push_back(mem_addr_o);
            szq.push_back(mem_size_o);
        end
        else
            mem_rdata_i <= mem.exists(mem_addr_o) ? mem[mem_addr_o] : '0;
    end
end
task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e)
    begin
        err_total++;
        $display("ERROR %s expected %h seen %h", nm, e, g);
    end
endtask
task wbx(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, 4'hf};
    {wb_adr_i, wb_dat_i} <= {a, d};
    do @(posedge ref_clk_i); while (wb_ack_o !== 1'b1);
    chk("wb_ack_o", 1'b1, wb_ack_o);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
endtask
task fire(input logic [1:0] k, input logic [7:0] op, input logic [7:0] im);
    int n;
    n = 0;
    wq.delete();
    @(posedge ref_clk_i);
    {opcode_i, imm_i} <= {op, im};
    {fp_vector_err_i, fp_legacy_err_i, instr_valid_i} <= 3'b001 << k;
    @(posedge ref_clk_i);
    {fp_vector_err_i, fp_legacy_err_i, instr_valid_i} <= 3'b000;
    do @(posedge ref_clk_i); while (done_o !== 1'b1 && ++n < 400);
    chk("done_o", 1'b1, done_o);
    {ld, ts} = {load_o, task_switch_o};
endtask
task run_real();
    {sp_i, cs_i, flags_i} <= {64'h0800, 16'h0100, 32'h0200};
    next_ip_i <= 64'h0055;
    fire(0, OP_BRK, 8'h00);
    chk("vector", VEC_BP, vector_o);
    chk("ip", 64'h0003, new_ip_o);
    chk("cs", 16'h0200, new_cs_o);
    chk("flags", 32'h0000, new_flags_o);
    chk("sp", 64'h07fa, new_sp_o);
    chk("first push", 64'h07fe, wq[0]);
    chk("saved flags", 64'h0200, mem[64'h07fe]);
    chk("saved cs", 64'h0100, mem[64'h07fc]);
    chk("saved ip", 64'h0055, mem[64'h07fa]);
    {sp_i, flags_i} <= {64'h07fa, 32'h0000};
    fire(0, OP_RET, 8'h00);
    chk("ret ip", 64'h0055, new_ip_o);
    chk("ret flags", 32'h0200, new_flags_o);
    chk("ret sp", 64'h0800, new_sp_o);
endtask
task run_codes();
    logic [7:0] ops [7] = '{OP_DBG, OP_SWINT, OP_OVF, OP_SWINT, OP_RANGE,
        8'h00, 8'h00};
    logic [7:0] ims [7] = '{8'h00, 8'h04, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00};
    logic [7:0] vs [7] = '{VEC_DB, VEC_OF, VEC_OF, VEC_BR, VEC_BR, VEC_MF,
        VEC_XM};
    logic [1:0] ks [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
    {flags_i, range_op_i, range_addr_i} <= {32'h0a00, 32'h0019, 64'h3000};
    foreach (vs[i])
    begin
        fire(ks[i], ops[i], ims[i]);
        chk("vector", vs[i], vector_o);
        chk("entry", vs[i], new_ip_o);
    end
endtask
task run_quiet();
    {flags_i, range_op_i} <= {32'h0200, 32'h0014};
    fire(0, OP_OVF, 8'h00);
    chk("quiet overflow", 1'b0, ld);
    fire(0, OP_RANGE, 8'h00);
    chk("range at limit", 1'b0, ld);
endtask
task run_long();
    wbx(1, REG_CTRL, 32'(MODE_LONG));
    wbx(1, REG_TBASE, 32'h2000);
    {cpl_i, priv_ss_i, ss_i} <= {2'h3, 16'h0018, 16'h002b};
    {priv_sp_i, sp_i} <= {64'h9000, 64'h7000};
    fire(0, OP_BRK, 8'h00);
    chk("code64", 1'b1, code64_o);
    chk("new ss", NULL_SEL, new_ss_o);
    chk("push count", 64'h0005, wq.size());
    chk("saved ss", 64'h002b, mem[64'h8ff8]);
    chk("saved sp", 64'h7000, mem[64'h8ff0]);
    chk("push size", SZ_8, szq[szq.size() - 1]);
endtask
task run_task();
    wbx(1, REG_CTRL, 32'h0001);
    {cpl_i, next_ip_i} <= {2'h0, 64'h0123};
    fire(0, OP_DBG, 8'h00);
    chk("task entry", 1'b1, ts);
    chk("task ip", 64'h8001, new_ip_o);
    next_ip_i <= 64'h0999;
    fire(0, OP_RET, 8'h00);
    chk("task return", 1'b1, ts);
    chk("restored ip", 64'h0123, new_ip_o);
endtask
task tally_and_finish();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask
initial
begin
    for (int i = 0; i < 32; i++)
    begin
        mem[64'h1000 + 4 * i] = {32'h0000, 16'h0200, 16'(i)};
        mem[64'h2000 + 8 * i] = {14'h0000, (i == 1) ? GATE_TASK : GATE_INT,
            16'h0300, 32'h8000 + 32'(i)};
    end
    {mem[64'h3000], mem[64'h3004]} = {64'h000a, 64'h0014};
    repeat (20) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    wbx(1, REG_TBASE, 32'h1000);
    wbx(1, REG_SBASE, 32'h4000);
    wbx(0, 8'h20, 32'h0000);
    chk("unmapped read", 32'h0000, q);
    run_real();
    run_codes();
    run_quiet();
    run_long();
    run_task();
    tally_and_finish();
end
endmodule // test_sid_dispatch
